//--- rtl/pce_defines.svh
`ifndef PCE_DEFINES_SVH
`define PCE_DEFINES_SVH

`define PCE_NUM_CMP 8
`define PCE_NUM_EVT 2
`define PCE_CNT_W 16
`define PCE_PER_W 4
`define PCE_FILT_LEN 3
`define PCE_TRG_OFF 2'h0
`define PCE_TRG_RESET 2'h1
`define PCE_TRG_START 2'h2
`define PCE_TRG_CBC 2'h3
`define PCE_CNT_RST 16'h0000
`define PCE_PER_RST 4'h0

`endif

//--- rtl/pce_pkg.sv
package pce_pkg;
   typedef enum logic [1:0] {
      PCE_MODE_OFF = 2'h0,
      PCE_MODE_RESET = 2'h1,
      PCE_MODE_START = 2'h2,
      PCE_MODE_CBC = 2'h3
   } pce_trig_mode_t;

   typedef enum logic [2:0] {
      PCE_ST_RUN = 3'h1,
      PCE_ST_WAIT = 3'h2,
      PCE_ST_IDLE = 3'h4
   } pce_ch_state_t;
endpackage

//--- rtl/pce_ch_if.sv
`timescale 1ns/10ps
interface pce_ch_if #(parameter int CW = 16);
   logic raw_trig;
   logic trig_event;
   logic trig_level;
   logic [1:0] mode;
   logic polarity;
   logic filter_en;
   modport owner (output raw_trig, output mode, output polarity, output filter_en,
      input trig_event, input trig_level);
   modport detect (input raw_trig, input mode, input polarity, input filter_en,
      output trig_event, output trig_level);
endinterface

//--- rtl/pce_trig_detect.sv
`timescale 1ns/10ps
`include "pce_defines.svh"
module pce_trig_detect #(
   parameter int FILT_LEN = `PCE_FILT_LEN
) (
   input wire logic sys_clk,
   input wire logic rst,
   pce_ch_if.detect ch
);
   logic sync1_reg;
   logic sync2_reg;
   logic [FILT_LEN-1:0] hist_reg;
   logic filt_reg;
   logic prev_reg;
   logic lvl;

   // two-stage synchroniser; only the second stage feeds the filter
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= ch.raw_trig;
         sync2_reg <= sync1_reg;
      end
   end

   // filter: level must be stable for FILT_LEN clocks before it moves
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         hist_reg <= '0;
         filt_reg <= 1'b0;
      end else begin
         hist_reg <= {hist_reg[FILT_LEN-2:0], sync2_reg};
         if (&hist_reg)
            filt_reg <= 1'b1;
         else if (~|hist_reg)
            filt_reg <= 1'b0;
      end
   end

   assign lvl = ch.filter_en ? filt_reg : sync2_reg;

   always_ff @(posedge sys_clk) begin
      if (rst)
         prev_reg <= 1'b0;
      else
         prev_reg <= lvl;
   end

   // polarity 1 = rising edge / high level, 0 = falling / low
   assign ch.trig_event = ch.polarity ? (lvl & ~prev_reg) : (~lvl & prev_reg);
   assign ch.trig_level = ch.polarity ? lvl : ~lvl;
endmodule

//--- rtl/pce_cmp_unit.sv
`timescale 1ns/10ps
`include "pce_defines.svh"
module pce_cmp_unit #(
   parameter int CW = `PCE_CNT_W,
   parameter int PW = `PCE_PER_W
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [CW-1:0] ch0_counter,
   input wire logic ch0_counting_down,
   input wire logic ch0_center,
   input wire logic ch0_period_end,
   input wire logic ch0_running,
   input wire logic ch0_fault,
   input wire logic wr_value,
   input wire logic [CW-1:0] value_shadow,
   input wire logic dir_shadow,
   input wire logic wr_mode,
   input wire logic en_shadow,
   input wire logic [PW-1:0] slot_shadow,
   input wire logic [PW-1:0] pmax_shadow,
   input wire logic [PW-1:0] upd_shadow,
   output logic match,
   output logic update_evt,
   output logic [PW-1:0] period_count,
   output logic [PW-1:0] update_count
);
   logic [CW-1:0] compare_value_reg;
   logic compare_direction_select_reg;
   logic compare_unit_enable_reg;
   logic [PW-1:0] compare_trigger_slot_reg;
   logic [PW-1:0] compare_period_max_reg;
   logic [PW-1:0] compare_update_period_reg;
   logic [CW-1:0] pend_value_reg;
   logic pend_dir_reg;
   logic pend_en_reg;
   logic [PW-1:0] pend_slot_reg;
   logic [PW-1:0] pend_pmax_reg;
   logic [PW-1:0] pend_upd_reg;
   logic pend_valid_reg;
   logic apply_now;
   logic dir_ok;

   // mode write validates the pair; a value write alone waits for it
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pend_value_reg <= '0;
         pend_dir_reg <= 1'b0;
         pend_en_reg <= 1'b0;
         pend_slot_reg <= '0;
         pend_pmax_reg <= '0;
         pend_upd_reg <= '0;
         pend_valid_reg <= 1'b0;
      end else begin
         if (wr_value) begin
            pend_value_reg <= value_shadow;
            pend_dir_reg <= dir_shadow;
         end
         if (wr_mode) begin
            pend_en_reg <= en_shadow;
            pend_slot_reg <= slot_shadow;
            pend_pmax_reg <= pmax_shadow;
            pend_upd_reg <= upd_shadow;
            pend_valid_reg <= 1'b1;
         end else if (apply_now) begin
            pend_valid_reg <= 1'b0;
         end
      end
   end

   // stopped channel: apply at once; running: at end of update period
   assign apply_now = pend_valid_reg & (~ch0_running |
      (ch0_period_end & (update_count == compare_update_period_reg)));

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         compare_value_reg <= '0;
         compare_direction_select_reg <= 1'b0;
         compare_unit_enable_reg <= 1'b0;
         compare_trigger_slot_reg <= '0;
         compare_period_max_reg <= '0;
         compare_update_period_reg <= '0;
      end else if (apply_now) begin
         compare_value_reg <= pend_value_reg;
         compare_direction_select_reg <= pend_dir_reg;
         compare_unit_enable_reg <= pend_en_reg;
         compare_trigger_slot_reg <= pend_slot_reg;
         compare_period_max_reg <= pend_pmax_reg;
         compare_update_period_reg <= pend_upd_reg;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst)
         period_count <= `PCE_PER_RST;
      else if (ch0_period_end)
         period_count <= (period_count >= compare_period_max_reg) ? '0 : period_count + 1'b1;
   end

   always_ff @(posedge sys_clk) begin
      if (rst)
         update_count <= `PCE_PER_RST;
      else if (ch0_period_end)
         update_count <= (update_count >= compare_update_period_reg) ? '0 : update_count + 1'b1;
   end

   assign dir_ok = ~ch0_center | (compare_direction_select_reg == ch0_counting_down);

   // slot and max both zero: count stays zero, so every period compares
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         match <= 1'b0;
         update_evt <= 1'b0;
      end else begin
         match <= compare_unit_enable_reg & ~ch0_fault & dir_ok & ch0_running
            & (ch0_counter == compare_value_reg)
            & (period_count == compare_trigger_slot_reg);
         update_evt <= apply_now & ch0_running;
      end
   end
endmodule

//--- rtl/pce_top.sv
// Behaviour
// - eight compare units watch channel-0 counter
// - match needs enable and equal counter
// - direction bit picks up/down when centered
// - channel-0 fault blocks all matches
// - compare only when period count equals slot
// - slot and max zero: every period
// - shadow writes applied once a mode write arrives, at update period end, or at once while channel 0 is stopped
// - match/update flags, enable mask, read clears
// - two event lines pulse on selected match
// - source bit: pin or analog comparator
// - filter bit filters selected trigger source
// - capture larger counter on trigger; read clears
// - mode 0 off, 1 reset, 2 start, 3 duty
// - reset mode: edge clears counter, restarts cycle
// - reset mode: period end also restarts
// - start mode: wait period end and level
// - duty mode keeps programmed period
// - duty mode: early trigger forces output inactive
// - duty mode edge chosen by polarity bit
// - ready flag may follow selected compare match
`timescale 1ns/10ps
`include "pce_defines.svh"
module pce_top #(
   parameter int NCMP = `PCE_NUM_CMP,
   parameter int CW = `PCE_CNT_W,
   parameter int PW = `PCE_PER_W
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [CW-1:0] ch0_counter,
   input wire logic ch0_counting_down,
   input wire logic alignment_select,
   input wire logic ch0_period_end,
   input wire logic ch0_running,
   input wire logic ch0_fault,
   input wire logic [NCMP-1:0] wr_value,
   input wire logic [NCMP*CW-1:0] compare_value_shadow,
   input wire logic [NCMP-1:0] compare_direction_shadow,
   input wire logic [NCMP-1:0] wr_mode,
   input wire logic [NCMP-1:0] compare_unit_enable_shadow,
   input wire logic [NCMP*PW-1:0] compare_trigger_slot_shadow,
   input wire logic [NCMP*PW-1:0] compare_period_max_shadow,
   input wire logic [NCMP*PW-1:0] compare_update_period_shadow,
   input wire logic [2*NCMP-1:0] event_compare_select,
   input wire logic [2*NCMP-1:0] irq_enable_set,
   input wire logic [2*NCMP-1:0] irq_enable_clear,
   input wire logic status_read,
   input wire logic ready_trigger_mode,
   input wire logic [2:0] ready_trigger_compare_select,
   input wire logic update_period_end,
   input wire logic ready_read,
   input wire logic [1:0] ext_trigger_input,
   input wire logic [1:0] analog_cmp_out,
   input wire logic [1:0] trigger_source_select,
   input wire logic [1:0] trigger_filter_enable,
   input wire logic [3:0] trigger_mode_select,
   input wire logic [1:0] trigger_polarity_select,
   input wire logic [1:0] trigger_reg_read,
   input wire logic [2*CW-1:0] period_value,
   input wire logic [2*CW-1:0] duty_value,
   output logic [2*CW-1:0] ch_counter,
   output logic [1:0] ch_output_active,
   output logic [2*CW-1:0] max_counter_capture,
   output logic [2*NCMP-1:0] cmp_status,
   output logic [2*NCMP-1:0] irq_enabled,
   output logic irq,
   output logic [1:0] event_line,
   output logic write_ready_flag,
   output logic dma_request,
   output logic [NCMP*PW-1:0] compare_period_count,
   output logic [NCMP*PW-1:0] compare_update_count
);
   logic [NCMP-1:0] match;
   logic [NCMP-1:0] upd_evt;
   logic [2*NCMP-1:0] evt_all;
   logic ready_src;

   // compare units
   genvar gi;
   generate
      for (gi = 0; gi < NCMP; gi++) begin : g_cmp
         pce_cmp_unit #(.CW(CW), .PW(PW)) u_cmp (
            .sys_clk(sys_clk),
            .rst(rst),
            .ch0_counter(ch0_counter),
            .ch0_counting_down(ch0_counting_down),
            .ch0_center(alignment_select),
            .ch0_period_end(ch0_period_end),
            .ch0_running(ch0_running),
            .ch0_fault(ch0_fault),
            .wr_value(wr_value[gi]),
            .value_shadow(compare_value_shadow[gi*CW +: CW]),
            .dir_shadow(compare_direction_shadow[gi]),
            .wr_mode(wr_mode[gi]),
            .en_shadow(compare_unit_enable_shadow[gi]),
            .slot_shadow(compare_trigger_slot_shadow[gi*PW +: PW]),
            .pmax_shadow(compare_period_max_shadow[gi*PW +: PW]),
            .upd_shadow(compare_update_period_shadow[gi*PW +: PW]),
            .match(match[gi]),
            .update_evt(upd_evt[gi]),
            .period_count(compare_period_count[gi*PW +: PW]),
            .update_count(compare_update_count[gi*PW +: PW])
         );
      end
   endgenerate

   assign evt_all = {upd_evt, match};

   // flags: set wins over the read-clear
   always_ff @(posedge sys_clk) begin
      if (rst)
         cmp_status <= '0;
      else if (status_read)
         cmp_status <= evt_all;
      else
         cmp_status <= cmp_status | evt_all;
   end

   always_ff @(posedge sys_clk) begin
      if (rst)
         irq_enabled <= '0;
      else
         irq_enabled <= (irq_enabled | irq_enable_set) & ~irq_enable_clear;
   end

   // irq is one cycle behind the flags, kept registered
   always_ff @(posedge sys_clk) begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= |(cmp_status & irq_enabled);
   end

   // event lines, one clock per match cycle
   generate
      for (gi = 0; gi < 2; gi++) begin : g_evt
         always_ff @(posedge sys_clk) begin
            if (rst)
               event_line[gi] <= 1'b0;
            else
               event_line[gi] <= |(match & event_compare_select[gi*NCMP +: NCMP]);
         end
      end
   endgenerate

   assign ready_src = ready_trigger_mode ? match[ready_trigger_compare_select] : update_period_end;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         write_ready_flag <= 1'b0;
         dma_request <= 1'b0;
      end else begin
         dma_request <= ready_src;
         if (ready_src)
            write_ready_flag <= 1'b1;
         else if (ready_read)
            write_ready_flag <= 1'b0;
      end
   end

   // external-trigger channels 1 and 2 (index 0 and 1 here)
   generate
      for (gi = 0; gi < 2; gi++) begin : g_ch
         pce_ch_if #(.CW(CW)) chi ();
         pce_pkg::pce_ch_state_t st_reg;
         logic [CW-1:0] cnt;
         logic [CW-1:0] prd;
         logic [CW-1:0] dty;
         logic at_end;
         logic ev;

         assign chi.raw_trig = trigger_source_select[gi] ? analog_cmp_out[gi] : ext_trigger_input[gi];
         assign chi.mode = trigger_mode_select[gi*2 +: 2];
         assign chi.polarity = trigger_polarity_select[gi];
         assign chi.filter_en = trigger_filter_enable[gi];

         pce_trig_detect u_det (
            .sys_clk(sys_clk),
            .rst(rst),
            .ch(chi.detect)
         );

         assign cnt = ch_counter[gi*CW +: CW];
         assign prd = period_value[gi*CW +: CW];
         assign dty = duty_value[gi*CW +: CW];
         assign at_end = (cnt >= prd);
         assign ev = chi.trig_event & (chi.mode != `PCE_TRG_OFF);

         always_ff @(posedge sys_clk) begin
            if (rst) begin
               st_reg <= pce_pkg::PCE_ST_RUN;
               ch_counter[gi*CW +: CW] <= `PCE_CNT_RST;
            end else begin
               unique case (st_reg)
                  pce_pkg::PCE_ST_RUN: begin
                     if (chi.mode == `PCE_TRG_RESET && ev)
                        ch_counter[gi*CW +: CW] <= '0;
                     else if (at_end && chi.mode == `PCE_TRG_START && !chi.trig_level) begin
                        st_reg <= pce_pkg::PCE_ST_WAIT;
                     end else if (at_end)
                        ch_counter[gi*CW +: CW] <= '0;
                     else
                        ch_counter[gi*CW +: CW] <= cnt + 1'b1;
                  end
                  pce_pkg::PCE_ST_WAIT: begin
                     if (chi.mode != `PCE_TRG_START || chi.trig_level) begin
                        ch_counter[gi*CW +: CW] <= '0;
                        st_reg <= pce_pkg::PCE_ST_RUN;
                     end
                  end
                  default: st_reg <= pce_pkg::PCE_ST_RUN;
               endcase
            end
         end

         // output active below duty; an early duty-mode trigger ends it
         always_ff @(posedge sys_clk) begin
            if (rst)
               ch_output_active[gi] <= 1'b0;
            // a new cycle starts active; start mode stays off until its level arrives
            else if (st_reg == pce_pkg::PCE_ST_WAIT || at_end || (chi.mode == `PCE_TRG_RESET && ev))
               ch_output_active[gi] <= chi.mode != `PCE_TRG_START || chi.trig_level;
            else if (chi.mode == `PCE_TRG_CBC && ev && cnt < dty)
               ch_output_active[gi] <= 1'b0;
            else if (cnt + 1'b1 >= dty)
               ch_output_active[gi] <= 1'b0;
         end

         // capture wins over the read-clear so an event is not lost
         always_ff @(posedge sys_clk) begin
            if (rst)
               max_counter_capture[gi*CW +: CW] <= `PCE_CNT_RST;
            else if (ev && (trigger_reg_read[gi] || cnt > max_counter_capture[gi*CW +: CW]))
               max_counter_capture[gi*CW +: CW] <= cnt;
            else if (trigger_reg_read[gi])
               max_counter_capture[gi*CW +: CW] <= '0;
         end
      end
   endgenerate
endmodule

//--- bench/pce_props.sv
`timescale 1ns/10ps
module pce_props #(
   parameter int NCMP = 8,
   parameter int CW = 16,
   parameter int PW = 4
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ch0_running,
   input wire logic ch0_fault,
   input wire logic [2*NCMP-1:0] event_compare_select,
   input wire logic [2*NCMP-1:0] irq_enable_set,
   input wire logic [2*NCMP-1:0] irq_enable_clear,
   input wire logic [1:0] trigger_reg_read,
   input wire logic [2*CW-1:0] period_value,
   input wire logic [2*CW-1:0] ch_counter,
   input wire logic [2*CW-1:0] max_counter_capture,
   input wire logic [2*NCMP-1:0] cmp_status,
   input wire logic [2*NCMP-1:0] irq_enabled,
   input wire logic irq,
   input wire logic [1:0] event_line
);
   logic irq_due;
   assign irq_due = |(cmp_status & irq_enabled);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   property p_fault;
      ch0_fault |-> ##2 event_line == 2'h0;
   endproperty
   a_fault: assert property (p_fault) else $error("event line during fault");
   property p_idle;
      !ch0_running |-> ##2 event_line == 2'h0;
   endproperty
   a_idle: assert property (p_idle) else $error("event line while stopped");
   property p_sel;
      event_line[1] |-> $past(event_compare_select[2*NCMP-1:NCMP]) != '0;
   endproperty
   a_sel: assert property (p_sel) else $error("event line without selected unit");
   property p_status;
      event_line[0] |-> (cmp_status[NCMP-1:0] & $past(event_compare_select[NCMP-1:0])) != '0;
   endproperty
   a_status: assert property (p_status) else $error("event without match flag");
   property p_irq;
      irq == $past(irq_due);
   endproperty
   a_irq: assert property (p_irq) else $error("irq not following enabled flags");
   property p_en_set;
      (irq_enable_set != '0 && irq_enable_clear == '0) |=> (irq_enabled & $past(irq_enable_set)) == $past(irq_enable_set);
   endproperty
   a_en_set: assert property (p_en_set) else $error("enable set lost");
   property p_en_clr;
      (irq_enable_clear != '0 && irq_enable_set == '0) |=> (irq_enabled & $past(irq_enable_clear)) == '0;
   endproperty
   a_en_clr: assert property (p_en_clr) else $error("enable clear lost");
   property p_bound;
      ch_counter[CW-1:0] <= period_value[CW-1:0] && ch_counter[2*CW-1:CW] <= period_value[2*CW-1:CW];
   endproperty
   a_bound: assert property (p_bound) else $error("channel counter past period");
   property p_max;
      trigger_reg_read == 2'h0 |=> max_counter_capture[CW-1:0] >= $past(max_counter_capture[CW-1:0])
         && max_counter_capture[2*CW-1:CW] >= $past(max_counter_capture[2*CW-1:CW]);
   endproperty
   a_max: assert property (p_max) else $error("max capture shrank without read");
endmodule

bind pce_top pce_props #(.NCMP(NCMP), .CW(CW), .PW(PW)) u_pce_props (.sys_clk, .rst, .ch0_running,
   .ch0_fault, .event_compare_select, .irq_enable_set, .irq_enable_clear, .trigger_reg_read,
   .period_value, .ch_counter, .max_counter_capture, .cmp_status, .irq_enabled, .irq, .event_line);

//--- bench/pce_ch0_model.sv
`timescale 1ns/10ps
module pce_ch0_model #(
   parameter logic [15:0] PER = 16'h0013
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic run,
   output logic [15:0] counter,
   output logic period_end,
   output logic running
);
   // counts up only; alignment and direction flags come from the bench
   always_ff @(posedge sys_clk) begin
      if (rst || !run) begin
         counter <= 16'h0000;
         running <= 1'b0;
      end else begin
         running <= 1'b1;
         counter <= (counter == PER) ? 16'h0000 : counter + 16'h0001;
      end
   end
   assign period_end = running && counter == PER;
endmodule

//--- bench/tb.sv
`timescale 1ns/10ps
module tb;
   typedef struct {time t; logic [35:0] v;} pce_note_t;
   logic sys_clk, rst, run, ch0_fault, status_read, ready_trigger_mode, update_period_end, ready_read, chk_on;
   logic ch0_counting_down, alignment_select, ch0_period_end, ch0_running, irq, write_ready_flag, dma_request;
   logic [15:0] ch0_counter, event_compare_select, irq_enable_set, irq_enable_clear, cmp_status, irq_enabled;
   logic [7:0] wr_value, wr_mode, compare_direction_shadow, compare_unit_enable_shadow, m;
   logic [127:0] compare_value_shadow;
   logic [31:0] compare_trigger_slot_shadow, compare_period_max_shadow, compare_update_period_shadow;
   logic [31:0] period_value, duty_value, ch_counter, max_counter_capture, compare_period_count;
   logic [31:0] compare_update_count, seed;
   logic [2:0] ready_trigger_compare_select;
   logic [1:0] ext_trigger_input, analog_cmp_out, trigger_source_select, trigger_filter_enable;
   logic [1:0] trigger_polarity_select, trigger_reg_read, ch_output_active, event_line;
   logic [3:0] trigger_mode_select;
   logic [15:0] cv [8];
   logic [3:0] pm [8], sl [8], pc [8];
   logic en [8], dr [8];
   pce_note_t q [$];
   pce_note_t n, o;
   int mismatches, num_checks;
   pce_top u_pce_top (.sys_clk, .rst, .ch0_counter, .ch0_counting_down, .alignment_select, .ch0_period_end,
      .ch0_running, .ch0_fault, .wr_value, .compare_value_shadow, .compare_direction_shadow, .wr_mode,
      .compare_unit_enable_shadow, .compare_trigger_slot_shadow, .compare_period_max_shadow,
      .compare_update_period_shadow, .event_compare_select, .irq_enable_set, .irq_enable_clear, .status_read,
      .ready_trigger_mode, .ready_trigger_compare_select, .update_period_end, .ready_read, .ext_trigger_input,
      .analog_cmp_out, .trigger_source_select, .trigger_filter_enable, .trigger_mode_select,
      .trigger_polarity_select, .trigger_reg_read, .period_value, .duty_value, .ch_counter, .ch_output_active,
      .max_counter_capture, .cmp_status, .irq_enabled, .irq, .event_line, .write_ready_flag, .dma_request,
      .compare_period_count, .compare_update_count);
   pce_ch0_model u_pce_ch0_model (.sys_clk, .rst, .run, .counter(ch0_counter), .period_end(ch0_period_end),
      .running(ch0_running));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   function automatic void rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
   endfunction
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // bounded wait for the trigger channel counter to land in [lo, hi]
   task automatic wait_rng(input int ch, input int lo, input int hi, input int lim);
      for (int i = 0; i < lim; i++) begin
         @(posedge sys_clk);
         if (ch_counter[ch*16 +: 16] >= lo && ch_counter[ch*16 +: 16] <= hi) return;
      end
      mismatches++;
      close_out();
   endtask
   // predictor: unit matches seen one edge ago meet this edge's select bits,
   // because the units register their match before the event lines do
   always @(posedge sys_clk) begin
      if (chk_on) begin
         n.v[1:0] = {|(m & event_compare_select[15:8]), |(m & event_compare_select[7:0])};
         n.v[2] = ready_trigger_mode ? m[ready_trigger_compare_select] : update_period_end;
         n.v[3] = n.v[2] | (n.v[3] & !ready_read);
         for (int u = 0; u < 8; u++) begin
            m[u] = en[u] && ch0_running && !ch0_fault && ch0_counter == cv[u] && pc[u] == sl[u]
               && (!alignment_select || dr[u] == ch0_counting_down);
            if (ch0_period_end) pc[u] = (pc[u] == pm[u]) ? 4'h0 : pc[u] + 4'h1;
            n.v[4+u*4 +: 4] = pc[u];
         end
         n.t = $time;
         q.push_back(n);
      end
   end
   // watcher: the oldest note meets the outputs it predicted
   always @(posedge sys_clk) begin
      if (q.size() > 0 && q[0].t < $time) begin
         o = q.pop_front();
         chk({28'h0, compare_period_count, write_ready_flag, dma_request, event_line}, 64'(o.v));
      end
   end
   initial begin
      {run, ch0_fault, status_read, ready_trigger_mode, update_period_end, ready_read, chk_on, m} = '0;
      n.v = '0;
      {ch0_counting_down, alignment_select, event_compare_select, irq_enable_set, irq_enable_clear} = '0;
      {wr_value, wr_mode, compare_direction_shadow, compare_unit_enable_shadow, compare_value_shadow} = '0;
      {compare_trigger_slot_shadow, compare_period_max_shadow, compare_update_period_shadow} = '0;
      {ready_trigger_compare_select, ext_trigger_input, analog_cmp_out, trigger_source_select} = '0;
      {trigger_filter_enable, trigger_polarity_select, trigger_reg_read, trigger_mode_select} = '0;
      period_value = {16'h00C8, 16'h00C8};
      duty_value = {16'h0064, 16'h0064};
      seed = 32'h0000C60D;
      rst = 1'b1;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      for (int u = 0; u < 8; u++) begin
         rnd();
         cv[u] = 16'h0001 + 16'(seed % 18);
         pm[u] = 4'(u % 4);
         sl[u] = 4'(u / 2 % (u % 4 + 1));
         en[u] = (u != 7);
         pc[u] = 4'h0;
         compare_value_shadow[u*16 +: 16] <= cv[u];
         compare_trigger_slot_shadow[u*4 +: 4] <= sl[u];
         compare_period_max_shadow[u*4 +: 4] <= pm[u];
         compare_unit_enable_shadow[u] <= en[u];
         dr[u] = seed[5];
         compare_direction_shadow[u] <= dr[u];
      end
      wr_value <= 8'hFF;
      @(posedge sys_clk);
      wr_value <= 8'h00;
      wr_mode <= 8'hFF;
      @(posedge sys_clk);
      wr_mode <= 8'h00;
      chk_on <= 1'b1;
      run <= 1'b1;
      repeat (600) begin
         @(posedge sys_clk);
         rnd();
         event_compare_select <= seed[15:0];
         ch0_fault <= seed[20:17] == 4'h0;
         {alignment_select, ch0_counting_down} <= seed[23:22];
         status_read <= seed[21];
         irq_enable_set <= seed[4] ? seed[31:16] : 16'h0000;
         irq_enable_clear <= (!seed[4] && seed[6]) ? seed[15:0] : 16'h0000;
         {ready_trigger_mode, ready_trigger_compare_select, update_period_end, ready_read} <= seed[29:24];
      end
      chk_on <= 1'b0;
      repeat (4) @(posedge sys_clk);
      // reset mode on both trigger channels; the unselected source must stay ignored
      for (int ch = 0; ch < 2; ch++) begin
         trigger_source_select[ch] <= 1'(ch);
         trigger_filter_enable[ch] <= 1'(ch);
         trigger_polarity_select[ch] <= 1'(ch == 0);
         ext_trigger_input[ch] <= 1'(ch);
         analog_cmp_out[ch] <= 1'(ch);
         trigger_mode_select[ch*2 +: 2] <= 2'h1;
         wait_rng(ch, 100, 110, 450);
         if (ch == 0) analog_cmp_out[0] <= 1'b1;
         else ext_trigger_input[1] <= 1'b0;
         repeat (8) @(posedge sys_clk);
         chk(32'(ch_counter[ch*16 +: 16] >= 16'h0064), 32'h1);
         if (ch == 0) ext_trigger_input[0] <= 1'b1;
         else analog_cmp_out[1] <= 1'b0;
         wait_rng(ch, 0, 9, 12);
         chk(32'(max_counter_capture[ch*16 +: 16] >= 16'h0064 && max_counter_capture[ch*16 +: 16] <= 16'h007D), 32'h1);
         trigger_reg_read[ch] <= 1'b1;
         @(posedge sys_clk);
         trigger_reg_read[ch] <= 1'b0;
         repeat (2) @(posedge sys_clk);
         chk(32'(max_counter_capture[ch*16 +: 16]), 32'h0);
         trigger_mode_select[ch*2 +: 2] <= 2'h0;
         {ext_trigger_input[ch], analog_cmp_out[ch]} <= 2'h0;
      end
      trigger_mode_select[1:0] <= 2'h2;
      wait_rng(0, 200, 200, 450);
      repeat (20) @(posedge sys_clk);
      chk(32'(ch_counter[15:0]), 32'h000000C8);
      ext_trigger_input[0] <= 1'b1;
      wait_rng(0, 0, 9, 12);
      ext_trigger_input[0] <= 1'b0;
      trigger_mode_select[1:0] <= 2'h3;
      wait_rng(0, 20, 30, 450);
      chk(32'(ch_output_active[0]), 32'h1);
      ext_trigger_input[0] <= 1'b1;
      repeat (8) @(posedge sys_clk);
      chk(32'(ch_output_active[0]), 32'h0);
      // a trigger that cleared the counter would need more than this bound
      wait_rng(0, 200, 200, 180);
      close_out();
   end
endmodule
